/* hw/ssot_timer.sv */
// Notes on behaviour
// R1 - Two groups of four; first is master.
// R2 - Master start lets slaves start same cycle.
// R3 - Sync bit: 0 independent, 1 follow master.
// R4 - Software keeps master sync bit at zero.
// R5 - Synced slave starts with master, no own run.
// R6 - Capture input rising edge copies count.
// R7 - Capture load raises capture interrupt status.
// R8 - Software loads compares from capture plus delays.
// R9 - Software updates compare 1 before next match.
// R10 - Toggle enables 11 invert on both matches.
// R11 - Software clears toggles after pulse ends.
// R12 - Mode selects tap 1 clock, rising capture.
// R13 - Clear code clears flip-flop, disables toggles.
// R14 - Mask can leave only compare 1 match.
// R15 - Software computes 3 ms delay, 2 ms pulse.
// R16 - No-delay variant inverts on capture.
// R17 - No-delay variant inverts on compare 1 match.
// R18 - Software keeps compare 0 below compare 1.
// R19 - Counter wraps from maximum to zero.
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module ssot_timer #(
	parameter int NCH = ssot_pkg::NUM_CH,
	parameter int CPG = ssot_pkg::CH_PER_GROUP
) (
	input  wire logic                        mclk,
	input  wire logic                        arst_n,
	input  wire logic [ssot_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic [NCH-1:0]              captureInput0,
	output logic      [NCH-1:0]              timerOutputPin,
	output logic                             timerIrq
);
	import ssot_pkg::*;

	logic [1:0]            rstSync;
	logic                  rstN;
	logic [NCH-1:0]        capMeta;
	logic [NCH-1:0]        capSync;
	logic [NCH-1:0]        capLast;
	logic [NCH-1:0]        capRise;
	logic [PRESC_W-1:0]    presc;
	logic [PRESC_W-1:0]    next_presc;
	ssot_chan_t            chans      [NCH];
	ssot_chan_t            next_chans [NCH];
	logic                  ack;
	logic                  next_ack;
	logic [31:0]           next_readdata;
	logic                  next_irq;
	logic [CH_BITS-1:0]    chSel;
	logic [5:0]            regOff;
	logic                  wrTake;

	// Merges a bus write into a register view under the byte enables.
	function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : mergeBe

	// Tick of a prescaler tap; the external source is handled by the caller.
	// Its external branch only keeps the case complete; that code never reaches here.
	function automatic logic tapTick(input logic [PRESC_W-1:0] p, input logic [1:0] sel);
		logic [PRESC_W-1:0] m;
		m = TAP3_MASK;
		unique case (sel)
			CLK_TAP1: m = TAP1_MASK;
			CLK_TAP2: m = TAP2_MASK;
			CLK_TAP3: m = TAP3_MASK;
			CLK_EXT:  m = TAP3_MASK;
		endcase
		return (p & m) == m;
	endfunction : tapTick

	// Reset is released through two flops so every flop leaves reset on the same edge.
	// Its copy is the asynchronous reset of every other flop in the block.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	// Capture pins are asynchronous; the first stage feeds only the second.
	// A pin already high when reset ends is seen as one rising edge.
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			capMeta <= '0;
			capSync <= '0;
			capLast <= '0;
		end else begin
			capMeta <= captureInput0;
			capSync <= capMeta;
			capLast <= capSync;
		end
	end
	// R6 rising edge
	assign capRise = capSync & ~capLast;

	assign chSel           = avs_address[ADDR_W-1:CH_LSB];
	assign regOff          = {avs_address[CH_LSB-1:2], 2'h0};
	assign wrTake          = avs_write && ack;
	// One wait cycle on every access keeps read data registered.
	// Limitation: every access costs two cycles, traded for a registered read path.
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	// Next state of the prescaler, all channels, the bus answer and the interrupt.
	always_comb begin
		logic        follow;
		logic        runReq;
		logic        tick;
		logic        capEdge;
		logic        m0;
		logic        m1;
		logic        ovf;
		logic [CNT_W-1:0] incr;
		logic [ST_W-1:0]  evt;
		logic [31:0] wv;
		logic        irqAcc;
		int          mIdx;
		follow        = 1'b0;
		runReq        = 1'b0;
		tick          = 1'b0;
		capEdge       = 1'b0;
		m0            = 1'b0;
		m1            = 1'b0;
		ovf           = 1'b0;
		incr          = CNT_RESET;
		evt           = '0;
		wv            = '0;
		irqAcc        = 1'b0;
		mIdx          = 0;
		// The prescaler runs from reset, so all channels share the same tap phases.
		next_presc    = presc + 8'h01;
		next_ack      = (avs_read || avs_write) && !ack;
		next_readdata = avs_readdata;
		for (int i = 0; i < NCH; i++) begin
			next_chans[i] = chans[i];
			// R1 group master
			mIdx = (i / CPG) * CPG;
			// A master's own sync bit is stored but never followed.
			// R3 sync select
			follow = chans[i].sync && (i != mIdx);
			// R2 R5 follow master
			runReq = follow ? (chans[mIdx].prun && chans[mIdx].run) : (chans[i].prun && chans[i].run);
			// R12 capture mode
			capEdge = capRise[i] && (chans[i].capMode == CAP_RISE0);
			// R12 count source
			tick = runReq && ((chans[i].clkSel == CLK_EXT) ? capRise[i] : tapTick(presc, chans[i].clkSel));
			// The carry is dropped on purpose, so the count wraps to zero.
			// R19 wrap around
			incr = chans[i].count + 16'h0001;
			// A match compares the next count, so flag and count land on one edge.
			m0   = tick && chans[i].running && (incr == chans[i].cmp0);
			m1   = tick && chans[i].running && (incr == chans[i].cmp1);
			ovf  = tick && chans[i].running && (chans[i].count == 16'hFFFF);
			next_chans[i].running = runReq;
			if (!runReq) begin
				next_chans[i].count = chans[i].count;
			end else if (!chans[i].running) begin
				// A start clears the count, so master and slaves line up exactly.
				next_chans[i].count = CNT_RESET;
			end else if (tick) begin
				next_chans[i].count = incr;
			end
			// R6 capture copy
			if (capEdge) begin
				next_chans[i].cap0 = chans[i].count;
			end
			// Two toggles in one cycle cancel; the compare values must differ.
			// R10 R16 R17 toggle flip-flop
			next_chans[i].ff = chans[i].ff ^ (chans[i].tog0 && m0) ^ (chans[i].tog1 && m1)
				^ (chans[i].togCap && capEdge);
			// R7 capture event
			evt = '0;
			evt[ST_MATCH0] = m0;
			evt[ST_MATCH1] = m1;
			evt[ST_OVF]    = ovf;
			evt[ST_CAP0]   = capEdge;
			next_chans[i].status = chans[i].status | evt;
			// Register writes; a status event in the clearing cycle survives.
			if (wrTake && (int'(chSel) == i)) begin
				unique case (regOff)
					OFF_CTRL: begin
						wv = mergeBe({31'h0, chans[i].sync}, avs_writedata, avs_byteenable);
						next_chans[i].sync = wv[CTRL_SYNC_BIT];
					end
					OFF_RUN: begin
						wv = mergeBe({29'h0, chans[i].prun, 1'b0, chans[i].run}, avs_writedata, avs_byteenable);
						next_chans[i].prun = wv[RUN_PRESC_BIT];
						next_chans[i].run  = wv[RUN_COUNT_BIT];
					end
					OFF_MODE: begin
						wv = mergeBe({27'h0, chans[i].capMode, 1'b0, chans[i].clkSel}, avs_writedata, avs_byteenable);
						next_chans[i].clkSel  = wv[MODE_CLK_LSB +: 2];
						next_chans[i].capMode = wv[MODE_CAP_LSB +: 2];
					end
					OFF_FFCTL: begin
						wv = mergeBe({27'h0, chans[i].togCap, chans[i].tog1, chans[i].tog0, FF_CODE_KEEP},
							avs_writedata, avs_byteenable);
						next_chans[i].tog0   = wv[FF_TOG0_BIT];
						next_chans[i].tog1   = wv[FF_TOG1_BIT];
						next_chans[i].togCap = wv[FF_TOGCAP_BIT];
						unique case (wv[FF_CODE_LSB +: 2])
							FF_CODE_CLEAR: begin
								// R13 clear and disable
								next_chans[i].ff     = 1'b0;
								next_chans[i].tog0   = 1'b0;
								next_chans[i].tog1   = 1'b0;
								next_chans[i].togCap = 1'b0;
							end
							FF_CODE_SET: begin
								next_chans[i].ff = 1'b1;
							end
							FF_CODE_INV: begin
								next_chans[i].ff = ~chans[i].ff;
							end
							FF_CODE_KEEP: begin
								next_chans[i].ff = next_chans[i].ff;
							end
						endcase
					end
					OFF_STATUS: begin
						wv = mergeBe(32'h0, avs_writedata, avs_byteenable);
						next_chans[i].status = (chans[i].status & ~wv[ST_W-1:0]) | evt;
					end
					OFF_MASK: begin
						// R14 per-source mask
						wv = mergeBe({28'h0, chans[i].mask}, avs_writedata, avs_byteenable);
						next_chans[i].mask = wv[ST_W-1:0];
					end
					OFF_CMP0: begin
						wv = mergeBe({16'h0, chans[i].cmp0}, avs_writedata, avs_byteenable);
						next_chans[i].cmp0 = wv[CNT_W-1:0];
					end
					OFF_CMP1: begin
						wv = mergeBe({16'h0, chans[i].cmp1}, avs_writedata, avs_byteenable);
						next_chans[i].cmp1 = wv[CNT_W-1:0];
					end
					default: begin
						wv = '0;
					end
				endcase
			end
			// One output serves all channels; software finds the source in the status words.
			// R14 masked interrupt
			irqAcc = irqAcc | (|(next_chans[i].status & ~next_chans[i].mask));
		end
		next_irq = irqAcc;
		// Read data is loaded on the first cycle so it stands while waitrequest is low.
		if (avs_read && !ack) begin
			next_readdata = 32'h0;
			unique case (regOff)
				OFF_CTRL:   next_readdata = {31'h0, chans[chSel].sync};
				OFF_RUN:    next_readdata = {29'h0, chans[chSel].prun, 1'b0, chans[chSel].run};
				OFF_MODE:   next_readdata = {27'h0, chans[chSel].capMode, 1'b0, chans[chSel].clkSel};
				OFF_FFCTL:  next_readdata = {26'h0, chans[chSel].ff, chans[chSel].togCap, chans[chSel].tog1,
					chans[chSel].tog0, FF_CODE_KEEP};
				OFF_STATUS: next_readdata = {28'h0, chans[chSel].status};
				OFF_MASK:   next_readdata = {28'h0, chans[chSel].mask};
				OFF_COUNT:  next_readdata = {16'h0, chans[chSel].count};
				OFF_CAP0:   next_readdata = {16'h0, chans[chSel].cap0};
				OFF_CMP0:   next_readdata = {16'h0, chans[chSel].cmp0};
				OFF_CMP1:   next_readdata = {16'h0, chans[chSel].cmp1};
				default:    next_readdata = 32'h0;
			endcase
		end
	end

	// Registers only; every channel resets stopped with its flip-flop low.
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			presc        <= '0;
			ack          <= 1'b0;
			avs_readdata <= 32'h0;
			timerIrq     <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				chans[i]      <= '0;
				chans[i].mask <= MASK_RESET;
			end
		end else begin
			presc        <= next_presc;
			ack          <= next_ack;
			avs_readdata <= next_readdata;
			timerIrq     <= next_irq;
			for (int i = 0; i < NCH; i++) begin
				chans[i] <= next_chans[i];
			end
		end
	end

	// The pin follows the flip-flop directly, so a toggle shows on the same edge as its match flag.
	// No output enable is needed, as the pin is always driven.
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			timerOutputPin[i] = chans[i].ff;
		end
	end

endmodule : ssot_timer

/* inc/ssot_pkg.sv */
package ssot_pkg;

	// Channel organisation: groups of four, the first of each group is the master.
	localparam int NUM_GROUPS   = 2;
	localparam int CH_PER_GROUP = 4;
	localparam int NUM_CH       = NUM_GROUPS * CH_PER_GROUP;
	localparam int CH_BITS      = 3;
	localparam int CNT_W        = 16;
	localparam int PRESC_W      = 8;

	// Byte address layout: channel index above a 64-byte register window.
	localparam int ADDR_W       = 9;
	localparam int CH_LSB       = 6;
	localparam logic [5:0] OFF_CTRL   = 6'h00;
	localparam logic [5:0] OFF_RUN    = 6'h04;
	localparam logic [5:0] OFF_MODE   = 6'h08;
	localparam logic [5:0] OFF_FFCTL  = 6'h0C;
	localparam logic [5:0] OFF_STATUS = 6'h10;
	localparam logic [5:0] OFF_MASK   = 6'h14;
	localparam logic [5:0] OFF_COUNT  = 6'h18;
	localparam logic [5:0] OFF_CAP0   = 6'h1C;
	localparam logic [5:0] OFF_CMP0   = 6'h20;
	localparam logic [5:0] OFF_CMP1   = 6'h24;

	// Field positions.
	localparam int CTRL_SYNC_BIT  = 0;
	localparam int RUN_COUNT_BIT  = 0;
	localparam int RUN_PRESC_BIT  = 2;
	localparam int MODE_CLK_LSB   = 0;
	localparam int MODE_CAP_LSB   = 3;
	localparam int FF_CODE_LSB    = 0;
	localparam int FF_TOG0_BIT    = 2;
	localparam int FF_TOG1_BIT    = 3;
	localparam int FF_TOGCAP_BIT  = 4;
	localparam int FF_STATE_BIT   = 5;
	localparam int ST_MATCH0      = 0;
	localparam int ST_MATCH1      = 1;
	localparam int ST_OVF         = 2;
	localparam int ST_CAP0        = 3;
	localparam int ST_W           = 4;

	// Field encodings.
	localparam logic [1:0] CLK_EXT       = 2'h0;
	localparam logic [1:0] CLK_TAP1      = 2'h1;
	localparam logic [1:0] CLK_TAP2      = 2'h2;
	localparam logic [1:0] CLK_TAP3      = 2'h3;
	localparam logic [1:0] CAP_RISE0     = 2'h1;
	localparam logic [1:0] FF_CODE_INV   = 2'h0;
	localparam logic [1:0] FF_CODE_SET   = 2'h1;
	localparam logic [1:0] FF_CODE_CLEAR = 2'h2;
	localparam logic [1:0] FF_CODE_KEEP  = 2'h3;

	// Prescaler taps: a tap ticks when all its mask bits of the prescaler are ones.
	localparam logic [PRESC_W-1:0] TAP1_MASK = 8'h01;
	localparam logic [PRESC_W-1:0] TAP2_MASK = 8'h07;
	localparam logic [PRESC_W-1:0] TAP3_MASK = 8'h1F;

	// Reset values.
	localparam logic [ST_W-1:0]  MASK_RESET = 4'h0;
	localparam logic [CNT_W-1:0] CNT_RESET  = 16'h0000;

	// Per-channel state.
	typedef struct packed {
		logic             sync;
		logic             prun;
		logic             run;
		logic             running;
		logic [1:0]       clkSel;
		logic [1:0]       capMode;
		logic             tog0;
		logic             tog1;
		logic             togCap;
		logic             ff;
		logic [ST_W-1:0]  status;
		logic [ST_W-1:0]  mask;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] cap0;
		logic [CNT_W-1:0] cmp0;
		logic [CNT_W-1:0] cmp1;
	} ssot_chan_t;

endpackage : ssot_pkg

/* verification/ssot_timer_properties.sv */
`timescale 1ns/1ps
module ssot_timer_properties #(
	parameter int NCH = ssot_pkg::NUM_CH
) (
	input wire logic                        mclk,
	input wire logic                        arst_n,
	input wire logic [ssot_pkg::ADDR_W-1:0] avs_address,
	input wire logic                        avs_read,
	input wire logic                        avs_write,
	input wire logic [31:0]                 avs_writedata,
	input wire logic [31:0]                 avs_readdata,
	input wire logic                        avs_waitrequest,
	input wire logic [NCH-1:0]              timerOutputPin
);
	import ssot_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Transfers counted at the edge that completes them.
	wire logic rdDone = avs_read && !avs_waitrequest;
	wire logic ffWr   = avs_write && !avs_waitrequest && avs_address[5:0] == OFF_FFCTL;
	sequence reqStart;
		$rose(avs_read || avs_write);
	endsequence
	sequence oneWait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	// Toggles are off in these writes, so the forced level must still show two edges on.
	property pinAfter(logic [1:0] code, logic lvl);
		logic [2:0] ch;
		(ffWr && avs_writedata[1:0] == code && avs_writedata[4:2] == 3'h0, ch = avs_address[8:6])
			|-> ##2 timerOutputPin[ch] == lvl;
	endproperty
	chk_single_wait: assert property (reqStart |-> oneWait) else $error("one wait cycle missed");
	chk_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait while idle");
	chk_unmapped_zero: assert property (rdDone && avs_address[5:0] >= 6'h28 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (rdDone |-> avs_readdata[31:16] == 16'h0) else $error("upper bits set");
	chk_code_reads: assert property (rdDone && avs_address[5:0] == OFF_FFCTL |-> avs_readdata[1:0] == 2'h3)
		else $error("code field not 3");
	chk_data_stands: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
	chk_clear_pin: assert property (pinAfter(FF_CODE_CLEAR, 1'b0)) else $error("clear missed");
	chk_set_pin: assert property (pinAfter(FF_CODE_SET, 1'b1)) else $error("set missed");
endmodule : ssot_timer_properties
bind ssot_timer ssot_timer_properties #(.NCH(NCH)) i_ssot_timer_properties (
	.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .timerOutputPin(timerOutputPin)
);

/* verification/ssot_pulse_model.sv */
`timescale 1ns/1ps
module ssot_pulse_model (
	input  wire logic       mclk,
	input  wire logic       fire,
	input  wire logic [2:0] chan,
	output logic      [7:0] capIn,
	input  wire logic [7:0] pinIn,
	output int              highCnt
);
	int pulseLeft;
	initial begin
		capIn = 8'h00;
		highCnt = 0;
		pulseLeft = 0;
	end
	// Trigger held six cycles so the two-flop synchroniser cannot miss it; the load counts high cycles.
	always @(posedge mclk) begin
		pulseLeft <= fire ? 6 : (pulseLeft > 0 ? pulseLeft - 1 : 0);
		highCnt <= fire ? 0 : highCnt + int'(pinIn[chan]);
		capIn <= (pulseLeft > 0) ? 8'h01 << chan : 8'h00;
	end
endmodule : ssot_pulse_model

/* verification/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin errorCnt++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	import ssot_pkg::*;
	localparam int DLY = 60; // Scaled delay in tap 1 ticks, short enough for the run.
	localparam int WID = 20;
	logic              mclk;
	logic              arst_n;
	logic [ADDR_W-1:0] addr;
	logic              rd;
	logic              wr;
	logic [31:0]       wdata;
	logic [31:0]       rdata;
	logic              waitReq;
	logic [7:0]        capIn;
	logic [7:0]        pinOut;
	logic              timerIrq;
	logic              fire;
	logic [2:0]        fireCh;
	int                highCnt;
	int                errorCnt;
	int                cmpCount;
	int                cycles;
	logic [31:0]       rdq;
	logic [15:0]       capVal;
	ssot_timer i_ssot_timer (.mclk(mclk), .arst_n(arst_n), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
		.avs_waitrequest(waitReq), .captureInput0(capIn), .timerOutputPin(pinOut), .timerIrq(timerIrq));
	ssot_pulse_model i_ssot_pulse_model (.mclk(mclk), .fire(fire), .chan(fireCh), .capIn(capIn),
		.pinIn(pinOut), .highCnt(highCnt));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// One transfer, held until wait is seen low at an edge.
	task automatic xfer(input logic w, input logic [2:0] ch, input logic [5:0] off, input logic [31:0] d);
		@(posedge mclk);
		rd <= ~w;
		wr <= w;
		addr <= {ch, off};
		wdata <= d;
		do @(posedge mclk); while (waitReq !== 1'b0);
		rdq = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : xfer
	task automatic rdc(input logic [2:0] ch, input logic [5:0] off, input logic [31:0] ex, input string nm);
		xfer(1'b0, ch, off, 32'h0);
		`CHK(nm, ex, rdq)
	endtask : rdc
	task automatic trig(input logic [2:0] ch);
		fireCh <= ch;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (12) @(posedge mclk);
	endtask : trig
	task automatic waitIrq;
		int n = 0;
		while (timerIrq !== 1'b1 && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		`CHK("irq", 1'b1, timerIrq)
	endtask : waitIrq
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	// A hang is cut short well past the expected run length.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errorCnt++;
			final_report();
		end
	end
	initial begin
		{rd, wr, fire, fireCh, addr, wdata, arst_n} = '0;
		{errorCnt, cmpCount, cycles} = '0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// Reset values, a read-only place and an unmapped place.
		rdc(3'd0, OFF_MASK, 32'h0, "mask reset");
		rdc(3'd0, OFF_FFCTL, 32'h3, "ffctl reset");
		xfer(1'b1, 3'd0, OFF_COUNT, 32'h1234);
		rdc(3'd0, OFF_COUNT, 32'h0, "count ro");
		rdc(3'd0, 6'h28, 32'h0, "unmapped");
		$display("test registers done");
		// Group start: channel 1 follows the master, channel 2 stays on its own.
		xfer(1'b1, 3'd0, OFF_CTRL, 32'h0);
		xfer(1'b1, 3'd1, OFF_CTRL, 32'h1);
		for (int c = 0; c < 3; c++) xfer(1'b1, c[2:0], OFF_MODE, 32'h1);
		xfer(1'b1, 3'd0, OFF_RUN, 32'h5);
		repeat (40) @(posedge mclk);
		xfer(1'b1, 3'd0, OFF_RUN, 32'h0);
		xfer(1'b0, 3'd0, OFF_COUNT, 32'h0);
		capVal = rdq[15:0];
		`CHK("master count", 1'b1, capVal > 16'h0)
		rdc(3'd1, OFF_COUNT, {16'h0, capVal}, "slave count");
		rdc(3'd2, OFF_COUNT, 32'h0, "solo count");
		$display("test sync done");
		// Delayed shot on channel 5, only the compare 1 match unmasked.
		xfer(1'b1, 3'd5, OFF_MODE, 32'h9);
		xfer(1'b1, 3'd5, OFF_FFCTL, 32'h2);
		xfer(1'b1, 3'd5, OFF_MASK, 32'hD);
		xfer(1'b1, 3'd5, OFF_RUN, 32'h5);
		trig(3'd5);
		rdc(3'd5, OFF_STATUS, 32'h8, "capture status");
		`CHK("irq masked", 1'b0, timerIrq)
		xfer(1'b0, 3'd5, OFF_CAP0, 32'h0);
		capVal = rdq[15:0];
		`CHK("capture value", 1'b1, capVal > 16'h0 && capVal < 16'h0014)
		xfer(1'b1, 3'd5, OFF_CMP0, {16'h0, capVal + 16'(DLY)});
		xfer(1'b1, 3'd5, OFF_CMP1, {16'h0, capVal + 16'(DLY + WID)});
		xfer(1'b1, 3'd5, OFF_FFCTL, 32'hF);
		waitIrq();
		`CHK("pulse width", 2 * WID, highCnt)
		rdc(3'd5, OFF_STATUS, 32'hB, "match status");
		xfer(1'b1, 3'd5, OFF_FFCTL, 32'h2);
		xfer(1'b1, 3'd5, OFF_STATUS, 32'hF);
		repeat (2) @(posedge mclk);
		`CHK("irq cleared", 1'b0, timerIrq)
		rdc(3'd5, OFF_FFCTL, 32'h3, "ffctl cleared");
		$display("test delayed shot done");
		// Set and clear codes, then the shot without delay on channel 6.
		xfer(1'b1, 3'd6, OFF_FFCTL, 32'h1);
		repeat (2) @(posedge mclk);
		`CHK("set code", 1'b1, pinOut[6])
		xfer(1'b1, 3'd6, OFF_FFCTL, 32'h2);
		repeat (2) @(posedge mclk);
		`CHK("clear code", 1'b0, pinOut[6])
		xfer(1'b1, 3'd6, OFF_MODE, 32'h9);
		xfer(1'b1, 3'd6, OFF_MASK, 32'hD);
		xfer(1'b1, 3'd6, OFF_FFCTL, 32'h1B);
		xfer(1'b1, 3'd6, OFF_RUN, 32'h5);
		trig(3'd6);
		`CHK("pin on capture", 1'b1, pinOut[6])
		xfer(1'b0, 3'd6, OFF_CAP0, 32'h0);
		xfer(1'b1, 3'd6, OFF_CMP1, {16'h0, rdq[15:0] + 16'(WID)});
		waitIrq();
		`CHK("pin after match", 1'b0, pinOut[6])
		`CHK("width", 1'b1, highCnt >= 2 * WID - 2 && highCnt <= 2 * WID + 2)
		$display("test plain shot done");
		// External clock and the invert code on channel 7, then tap 2 on channel 3.
		xfer(1'b1, 3'd7, OFF_RUN, 32'h5);
		trig(3'd7);
		trig(3'd7);
		rdc(3'd7, OFF_COUNT, 32'h2, "ext count");
		xfer(1'b1, 3'd7, OFF_FFCTL, 32'h0);
		repeat (2) @(posedge mclk);
		`CHK("invert code", 1'b1, pinOut[7])
		xfer(1'b1, 3'd7, OFF_FFCTL, 32'h0);
		repeat (2) @(posedge mclk);
		`CHK("invert back", 1'b0, pinOut[7])
		xfer(1'b1, 3'd3, OFF_MODE, 32'h2);
		xfer(1'b1, 3'd3, OFF_RUN, 32'h5);
		repeat (80) @(posedge mclk);
		xfer(1'b1, 3'd3, OFF_RUN, 32'h0);
		xfer(1'b0, 3'd3, OFF_COUNT, 32'h0);
		capVal = rdq[15:0];
		`CHK("tap2 count", 1'b1, capVal >= 16'h000A && capVal <= 16'h000B)
		$display("test clock sources done");
		final_report();
	end
endmodule : testbench
